/* File: dv/host_serial_model.sv */
`timescale 1ns/1ps
module host_serial_model (
  // link clock and frame request
  input  wire logic                 link_clk_i,
  input  wire logic                 start_i,
  input  wire logic                 edge_i,
  input  wire logic [4:0]           off_i,
  input  wire logic [31:0]          base_i,
  // serial pins and completion
  output rx_capture_pkg::serial_in_t ser_o,
  output logic                      done_o
);
  import rx_capture_pkg::*;
  int          i;   // bit position in the frame
  int          p;   // position in the shifted word stream
  logic [31:0] w1;  // word on the first pin
  logic [31:0] w2;  // word on the second pin
  // one tdm frame: sync on falling edge, data ahead of its capture edge
  task automatic send_frame();
    for (i = 0; i < 1024 + int'(off_i); i++) begin
      if (i > 0) @(negedge link_clk_i);
      ser_o.frame_sync <= (i == 0);
      if (edge_i) @(posedge link_clk_i);
      p = i - int'(off_i);
      w1 = base_i + 32'(2 * (p / 32));
      w2 = w1 + 32'h1;
      if (p < 0) begin
        // filler before the delayed msb keeps changing
        {ser_o.din1, ser_o.second_serial_data_input} <= ~{ser_o.din1, ser_o.second_serial_data_input};
      end else begin
        {ser_o.din1, ser_o.second_serial_data_input} <= {w1[31 - p % 32], w2[31 - p % 32]};
      end
    end
  endtask : send_frame
  // idle lines toggle so no stale bit can pass for data
  initial begin
    ser_o = '0;
    done_o = 1'b0;
    forever begin
      @(negedge link_clk_i);
      if (start_i && !done_o) begin
        send_frame();
        done_o <= 1'b1;
      end else begin
        if (!start_i) done_o <= 1'b0;
        ser_o <= '{din1: ~ser_o.din1, second_serial_data_input: ~ser_o.second_serial_data_input, frame_sync: 1'b0};
      end
    end
  end
endmodule : host_serial_model

/* File: dv/rx_capture_properties.sv */
`timescale 1ns/1ps
module rx_capture_properties (
  // system side
  input wire logic                        clk_i,
  input wire logic                        rst_i,
  input wire logic                        ce_i,
  input wire rx_capture_pkg::wb_req_t     wb_i,
  input wire rx_capture_pkg::wb_rsp_t     wb_o,
  // link side and outputs
  input wire logic                        link_clk_i,
  input wire rx_capture_pkg::serial_in_t  ser_i,
  input wire rx_capture_pkg::serial_out_t ser_o,
  input wire logic                        bclk_int_sel_o,
  input wire rx_capture_pkg::words_t      samples_o,
  input wire logic                        samples_valid_o
);
  import rx_capture_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // request taken by the slave on this edge
  sequence s_taken; wb_i.cyc && wb_i.stb && !wb_o.ack && ce_i; endsequence
  // an acknowledge now or on one of the two edges before
  sequence s_recent_ack; wb_o.ack || $past(wb_o.ack) || $past(wb_o.ack, 2); endsequence
  property p_ack_next; s_taken |=> wb_o.ack; endproperty
  property p_ack_pulse; wb_o.ack |=> !wb_o.ack; endproperty
  property p_ack_cause; $rose(wb_o.ack) |-> $past(wb_i.cyc && wb_i.stb); endproperty
  property p_dat_upper; wb_o.ack |-> wb_o.dat[31:16] == 16'h0000; endproperty
  property p_valid_pulse; samples_valid_o |=> !samples_valid_o; endproperty
  property p_samples_hold; $changed(samples_o) |-> samples_valid_o; endproperty
  property p_bclk_sel_cause; $changed(bclk_int_sel_o) |-> s_recent_ack; endproperty
  property p_oe_follow; $rose(bclk_int_sel_o) |-> ##[0:200] ser_o.frame_sync_oe; endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("no ack one cycle after a request");
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held longer than one cycle");
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without a request");
  a_dat_upper: assert property (p_dat_upper)
    else $error("read data has bits above the fields");
  a_valid_pulse: assert property (p_valid_pulse)
    else $error("sample strobe held longer than one cycle");
  a_samples_hold: assert property (p_samples_hold)
    else $error("captured words changed without strobe");
  a_bclk_sel_cause: assert property (p_bclk_sel_cause)
    else $error("bit clock select moved without a bus write");
  a_oe_follow: assert property (p_oe_follow)
    else $error("frame sync not driven in controller mode");
endmodule : rx_capture_properties

bind serial_audio_rx_capture_cfg rx_capture_properties chk_u (.clk_i, .rst_i, .ce_i, .wb_i,
  .wb_o, .link_clk_i, .ser_i, .ser_o, .bclk_int_sel_o, .samples_o, .samples_valid_o);

/* File: dv/serial_audio_rx_capture_cfg_tb.sv */
`timescale 1ns/1ps
module serial_audio_rx_capture_cfg_tb;
  import rx_capture_pkg::*;
  // one capture case: edge, offset, pin map, slot layout, word base
  typedef struct packed {
    logic        edge_sel;
    logic [4:0]  off;
    logic [7:0]  pins;
    logic [4:0]  sbase;
    logic [4:0]  sstep;
    logic [31:0] base;
  } row_t;
  localparam row_t ROWS [3] = '{'{1'b0, 5'h00, 8'h00, 5'h00, 5'h01, 32'h1000_0000},
                                '{1'b1, 5'h05, 8'hA5, 5'h18, 5'h01, 32'h2000_0000},
                                '{1'b0, 5'h1F, 8'hFF, 5'h03, 5'h04, 32'h3000_0000}};
  logic        clk_i, rst_i, ce_i, link_clk_i;  // clocks and controls
  logic        start, done;                     // frame request to the host model
  wb_req_t     wb_i;                            // bus request
  wb_rsp_t     wb_o;                            // bus answer
  serial_in_t  ser_i;                           // pins from the host
  serial_out_t ser_o;                           // frame sync drive
  logic        bclk_int_sel_o, samples_valid_o;
  words_t      samples_o;
  row_t        cur;                             // case in progress
  logic [31:0] rd;                              // last read data
  logic [4:0]  slot;                            // expected slot of a channel
  int          miscompares, cmp_count, r, c, k;
  // clocks: system 5 ns, link 80 ns with its own phase
  always #2.5 clk_i = ~clk_i;
  initial begin
    link_clk_i = 1'b0;
    #13;
    forever #40 link_clk_i = ~link_clk_i;
  end
  serial_audio_rx_capture_cfg dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_i(wb_i),
    .wb_o(wb_o), .link_clk_i(link_clk_i), .ser_i(ser_i), .ser_o(ser_o),
    .bclk_int_sel_o(bclk_int_sel_o), .samples_o(samples_o), .samples_valid_o(samples_valid_o));
  host_serial_model model_u (.link_clk_i(link_clk_i), .start_i(start), .edge_i(cur.edge_sel),
    .off_i(cur.off), .base_i(cur.base), .ser_o(ser_i), .done_o(done));
  // compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk
  // one classic cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d,
                    input logic [3:0] sel, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {2'h0, idx, 2'h0}, sel: sel, dat: {24'h0, d}};
    for (n = 0; n < 16; n++) begin
      @(posedge clk_i);
      if (wb_o.ack === 1'b1) break;
    end
    q = wb_o.dat;
    if (n == 16) chk("bus ack", 32'h0, 32'h1);
    wb_i <= '0;
  endtask : wb
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    wb(1'b1, idx, d, 4'h1, rd);
  endtask : wr
  task automatic rdc(input string what, input logic [7:0] idx, input logic [31:0] exp);
    wb(1'b0, idx, 8'h00, 4'h1, rd);
    chk(what, rd, exp);
  endtask : rdc
  // poll status until the link side holds the new setup
  task automatic settle();
    int n;
    for (n = 0; n < 40; n++) begin
      wb(1'b0, IDX_STATUS, 8'h00, 4'h1, rd);
      if (rd[PEND_BIT] === 1'b0) break;
    end
    chk("config pending", {31'h0, rd[PEND_BIT]}, 32'h0);
  endtask : settle
  task automatic finish_test();
    if (miscompares == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test
  // watchdog well past three frames and the register work
  initial begin
    repeat (90000) @(posedge clk_i);
    miscompares++;
    finish_test();
  end
  initial begin
    clk_i = 1'b0; rst_i = 1'b1; ce_i = 1'b1; wb_i = '0; start = 1'b0;
    cur = ROWS[0]; miscompares = 0; cmp_count = 0;
    // reset spans three link edges so the link side clears too
    repeat (60) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc("capture config", IDX_CAPTURE_CFG, 32'h0);
    rdc("pin select", IDX_PIN_SEL, 32'h0);
    wr(8'h10, 8'h5A);
    rdc("unmapped", 8'h10, 32'h0);
    wb(1'b1, IDX_PIN_SEL, 8'hFF, 4'hE, rd);
    rdc("lane masked", IDX_PIN_SEL, 32'h0);
    // capture cases: one frame each, words checked per channel
    for (r = 0; r < 3; r++) begin
      cur = ROWS[r];
      wr(IDX_CAPTURE_CFG, {cur.edge_sel, 2'b00, cur.off});
      wr(IDX_PIN_SEL, cur.pins);
      for (c = 0; c < 8; c++) wr(IDX_SLOT_FIRST + 8'(c), {3'h0, 5'(cur.sbase + 5'(c) * cur.sstep)});
      rdc("capture config", IDX_CAPTURE_CFG, {24'h0, cur.edge_sel, 2'b00, cur.off});
      rdc("pin select", IDX_PIN_SEL, {24'h0, cur.pins});
      settle();
      start <= 1'b1;
      for (k = 0; k < 20000 && done !== 1'b1; k++) @(posedge clk_i);
      start <= 1'b0;
      for (k = 0; k < 400 && samples_valid_o !== 1'b1; k++) @(posedge clk_i);
      chk("frame published", {31'h0, samples_valid_o}, 32'h1);
      for (c = 0; c < 8; c++) begin
        slot = cur.sbase + 5'(c) * cur.sstep;
        chk("channel word", samples_o[c], cur.base + 32'(2 * slot) + 32'(cur.pins[c]));
      end
    end
    // controller mode with internal clock and sync, then back
    wr(IDX_PORT_CTRL, 8'h01);
    wr(IDX_CAPTURE_CFG, 8'h60);
    settle();
    chk("internal bit clock", {31'h0, bclk_int_sel_o}, 32'h1);
    // the drive enable lands one link clock after the setup is taken
    for (k = 0; k < 64 && ser_o.frame_sync_oe !== 1'b1; k++) @(posedge clk_i);
    chk("frame sync drive", {31'h0, ser_o.frame_sync_oe}, 32'h1);
    // the internal sync idles low, then pulses once per 1024 link clocks
    for (k = 0; k < 200 && ser_o.frame_sync !== 1'b0; k++) @(posedge clk_i);
    for (k = 0; k < 16600 && ser_o.frame_sync !== 1'b1; k++) @(posedge clk_i);
    chk("internal frame sync", {31'h0, ser_o.frame_sync}, 32'h1);
    wr(IDX_PORT_CTRL, 8'h00);
    settle();
    chk("external bit clock", {31'h0, bclk_int_sel_o}, 32'h0);
    // a request made while the clock enable is low waits for it
    @(posedge clk_i);
    ce_i <= 1'b0;
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: 1'b1, adr: {2'h0, IDX_PIN_SEL, 2'h0}, sel: 4'h1,
              dat: 32'h0000_0011};
    repeat (4) @(posedge clk_i);
    chk("frozen ack", {31'h0, wb_o.ack}, 32'h0);
    ce_i <= 1'b1;
    for (k = 0; k < 16 && wb_o.ack !== 1'b1; k++) @(posedge clk_i);
    wb_i <= '0;
    rdc("pin select after freeze", IDX_PIN_SEL, 32'h0000_0011);
    // second reset in mid-run clears the setup
    wr(IDX_CAPTURE_CFG, 8'hFF);
    wr(IDX_PIN_SEL, 8'h3C);
    rst_i <= 1'b1;
    repeat (60) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc("capture config", IDX_CAPTURE_CFG, 32'h0);
    rdc("pin select", IDX_PIN_SEL, 32'h0);
    finish_test();
  end
endmodule : serial_audio_rx_capture_cfg_tb

/* File: hdl/rx_capture_pkg.sv */
package rx_capture_pkg;

  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_CAPTURE_CFG = 8'h26;  // rx_capture_config
  localparam logic [7:0] IDX_PIN_SEL     = 8'h27;  // rx_channel_pin_select
  localparam logic [7:0] IDX_SLOT_FIRST  = 8'h28;  // channel 1 slot number
  localparam logic [7:0] IDX_SLOT_LAST   = 8'h2F;  // channel 8 slot number
  localparam logic [7:0] IDX_PORT_CTRL   = 8'h30;  // mode, polarity, format
  localparam logic [7:0] IDX_STATUS      = 8'h31;  // pending flag, frame count

  // field positions
  localparam int unsigned EDGE_BIT      = 7;
  localparam int unsigned INT_FS_BIT    = 6;
  localparam int unsigned INT_BCLK_BIT  = 5;
  localparam int unsigned OFFSET_LSB    = 0;
  localparam int unsigned OFFSET_W      = 5;
  localparam int unsigned SLOT_LSB      = 0;
  localparam int unsigned CTRL_MODE_BIT = 0;
  localparam int unsigned POL_BIT       = 1;
  localparam int unsigned FMT_LSB       = 2;
  localparam int unsigned PEND_BIT      = 0;
  localparam int unsigned FCNT_LSB      = 8;

  // frame geometry: 32-bit words, 32 slots or two halves of 16
  localparam int unsigned N_CHAN    = 8;
  localparam int unsigned SLOT_W    = 5;
  localparam int unsigned WORD_BITS = 32;
  localparam int unsigned POS_W     = 10;
  localparam logic [POS_W-1:0] HALF_LAST  = 10'h1FF;
  localparam logic [POS_W-1:0] FRAME_LAST = 10'h3FF;
  localparam logic [5:0]       I2S_LAG    = 6'h01;   // standard one-bit delay

  // frame formats
  localparam logic [1:0] FMT_TDM = 2'h0;
  localparam logic [1:0] FMT_I2S = 2'h1;
  localparam logic [1:0] FMT_LJ  = 2'h2;

  // configuration image shared by both clock domains
  typedef struct packed {
    logic                         edge_sel;   // rx_capture_edge_sel
    logic                         int_fs;     // rx_internal_frame_sync_sel
    logic                         int_bclk;   // rx_internal_bit_clock_sel
    logic [OFFSET_W-1:0]          offset;     // rx_msb_slot_offset
    logic [N_CHAN-1:0]            pin_sel;    // rx_chanN_pin_sel, bit n-1
    logic [N_CHAN-1:0][SLOT_W-1:0] slot;      // rx_chanN_slot_number
    logic                         ctrl_mode;  // device drives frame sync
    logic                         pol;        // bit_clock_polarity
    logic [1:0]                   fmt;        // frame format
  } cfg_t;

  // reset values
  localparam logic [N_CHAN-1:0][SLOT_W-1:0] SLOT_RST =
    {5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00};
  localparam cfg_t CFG_RST = cfg_t'{1'b0, 1'b0, 1'b0, 5'h00, 8'h00, SLOT_RST,
                                    1'b0, 1'b0, 2'h0};

  typedef logic [N_CHAN-1:0][WORD_BITS-1:0] words_t;

  // wishbone request and response
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [11:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;

  // serial pins
  typedef struct packed {
    logic din1;   // first serial data input
    logic second_serial_data_input;   // second_serial_data_input
    logic frame_sync;  // frame_sync pin level
  } serial_in_t;
  typedef struct packed {
    logic frame_sync;     // frame_sync drive value
    logic frame_sync_oe;  // high while the device drives frame_sync
  } serial_out_t;

  typedef enum logic [1:0] {CAP_IDLE, CAP_RUN} cap_state_t;

endpackage : rx_capture_pkg

/* File: hdl/serial_audio_rx_capture_cfg.sv */
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
module serial_audio_rx_capture_cfg (
  // system clock domain
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        ce_i,
  // register bus
  input  wire rx_capture_pkg::wb_req_t     wb_i,
  output      rx_capture_pkg::wb_rsp_t     wb_o,
  // serial link, on the latching bit clock
  input  wire logic                        link_clk_i,
  input  wire rx_capture_pkg::serial_in_t  ser_i,
  output      rx_capture_pkg::serial_out_t ser_o,
  // bit clock source select to the clock mux
  output      logic                        bclk_int_sel_o,
  // captured words
  output      rx_capture_pkg::words_t      samples_o,
  output      logic                        samples_valid_o
);
  import rx_capture_pkg::*;

  // system domain state
  typedef struct packed {
    cfg_t                regs;      // software view
    cfg_t                hold;      // image offered to the link side
    logic                req;       // config offer toggle
    logic                ack_s1;    // link echo, first stage
    logic                ack_s2;    // link echo, second stage
    logic                pub_s1;    // publish toggle, first stage
    logic                pub_s2;    // publish toggle, second stage
    logic                pub_seen;  // last publish toggle taken
    words_t              samples;   // words of the last frame
    logic                valid;     // one-cycle new-frame pulse
    logic [7:0]          fcnt;      // frames received
    logic                bsel;      // internal bit clock selected
    logic                ack;       // bus acknowledge
    logic [31:0]         rdat;      // bus read data
  } sys_t;

  // link domain state
  typedef struct packed {
    cfg_t                cfg;       // applied configuration
    logic                req_s1;    // offer toggle, first stage
    logic                req_s2;    // offer toggle, second stage
    logic                req_seen;  // echoed back to the system side
    serial_in_t          pos_d;     // pins taken on the rising edge
    logic                fs_prev;   // frame sync of the previous bit
    logic                armed;     // offset count in progress
    logic [5:0]          skip;      // bits left before slot 0 MSB
    logic                half_arm;  // half of the pending start
    logic                half;      // 1 while in the right half
    cap_state_t          state;     // capture running or idle
    logic [POS_W-1:0]    pos;       // bit position in half or frame
    words_t              sh;        // per-channel shift registers
    words_t              hold;      // finished frame for crossing
    logic                pub;       // publish toggle
    logic [POS_W-1:0]    gen;       // internal frame sync counter
    logic                fs_out;    // internal frame sync level
    logic                fs_oe;     // frame sync drive enable
  } link_t;

  sys_t        s_r;       // system state
  sys_t        s_nxt;     // its next value
  link_t       l_r;       // link state
  link_t       l_nxt;     // its next value
  serial_in_t  neg_r;     // pins taken on the falling edge
  logic        lrst_s1;   // link reset, first stage
  logic        lrst_s2;   // link reset, second stage
  logic [7:0]  idx;       // register index from the bus
  logic [31:0] rd;        // read mux

  // ---------------- system domain ----------------

  // register access, config offer and frame pickup
  always_comb begin
    rd    = 32'h0000_0000;
    idx   = wb_i.adr[9:2];
    s_nxt = s_r;
    s_nxt.valid = 1'b0;
    s_nxt.ack   = 1'b0;
    // read mux, unmapped indices read zero
    if (idx == IDX_CAPTURE_CFG) begin
      rd[EDGE_BIT]                  = s_r.regs.edge_sel;
      rd[INT_FS_BIT]                = s_r.regs.int_fs;
      rd[INT_BCLK_BIT]              = s_r.regs.int_bclk;
      rd[OFFSET_LSB +: OFFSET_W]    = s_r.regs.offset;
    end else if (idx == IDX_PIN_SEL) begin
      rd[N_CHAN-1:0] = s_r.regs.pin_sel;
    end else if (idx >= IDX_SLOT_FIRST && idx <= IDX_SLOT_LAST) begin
      rd[SLOT_LSB +: SLOT_W] = s_r.regs.slot[idx[2:0]];
    end else if (idx == IDX_PORT_CTRL) begin
      rd[CTRL_MODE_BIT] = s_r.regs.ctrl_mode;
      rd[POL_BIT]       = s_r.regs.pol;
      rd[FMT_LSB +: 2]  = s_r.regs.fmt;
    end else if (idx == IDX_STATUS) begin
      rd[PEND_BIT]      = (s_r.req != s_r.ack_s2) || (s_r.regs != s_r.hold);
      rd[FCNT_LSB +: 8] = s_r.fcnt;
    end
    // one wait state, ack drops the cycle after it rises
    if (wb_i.cyc && wb_i.stb && !s_r.ack) begin
      s_nxt.ack  = 1'b1;
      s_nxt.rdat = rd;
      if (wb_i.we && wb_i.sel[0]) begin
        if (idx == IDX_CAPTURE_CFG) begin
          s_nxt.regs.edge_sel = wb_i.dat[EDGE_BIT];
          s_nxt.regs.int_fs   = wb_i.dat[INT_FS_BIT];
          s_nxt.regs.int_bclk = wb_i.dat[INT_BCLK_BIT];
          s_nxt.regs.offset   = wb_i.dat[OFFSET_LSB +: OFFSET_W];
        end else if (idx == IDX_PIN_SEL) begin
          s_nxt.regs.pin_sel = wb_i.dat[N_CHAN-1:0];
        end else if (idx >= IDX_SLOT_FIRST && idx <= IDX_SLOT_LAST) begin
          s_nxt.regs.slot[idx[2:0]] = wb_i.dat[SLOT_LSB +: SLOT_W];
        end else if (idx == IDX_PORT_CTRL) begin
          s_nxt.regs.ctrl_mode = wb_i.dat[CTRL_MODE_BIT];
          s_nxt.regs.pol       = wb_i.dat[POL_BIT];
          s_nxt.regs.fmt       = wb_i.dat[FMT_LSB +: 2];
        end
      end
    end
    // clock mux select follows controller mode and the select bit
    s_nxt.bsel = s_r.regs.ctrl_mode & s_r.regs.int_bclk;
    // echo of the link side, two stages
    s_nxt.ack_s1 = l_r.req_seen;
    s_nxt.ack_s2 = s_r.ack_s1;
    // offer a new image only when the last one was taken
    if (s_r.req == s_r.ack_s2 && s_r.regs != s_r.hold) begin
      s_nxt.hold = s_r.regs;
      s_nxt.req  = ~s_r.req;
    end
    // frame publish toggle, two stages then edge
    s_nxt.pub_s1 = l_r.pub;
    s_nxt.pub_s2 = s_r.pub_s1;
    if (s_r.pub_s2 != s_r.pub_seen) begin
      // link hold is stable for a whole frame after the toggle
      s_nxt.pub_seen = s_r.pub_s2;
      s_nxt.samples  = l_r.hold;
      s_nxt.valid    = 1'b1;
      s_nxt.fcnt     = s_r.fcnt + 8'h01;
    end
  end

  // system register, frozen while ce_i is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r      <= '0;
      s_r.regs <= CFG_RST;
      s_r.hold <= CFG_RST;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  // ---------------- link domain ----------------

  // reset carried into the link domain
  always_ff @(posedge link_clk_i) begin
    lrst_s1 <= rst_i;
    lrst_s2 <= lrst_s1;
  end

  // falling-edge pin sample, half a bit after the rising one
  always_ff @(negedge link_clk_i) begin
    if (lrst_s2) begin
      neg_r <= '0;
    end else begin
      neg_r <= ser_i;
    end
  end

  serial_in_t       smp;        // data sample on the chosen edge
  logic             fs_now;     // frame sync used for latching
  logic             ev;         // frame sync transition seen
  logic             ev_half;    // transition opens the right half
  logic             is_tdm;     // tdm format
  logic             is_i2s;     // i2s format
  logic [5:0]       delay;      // standard delay plus offset
  logic             start_now;  // this bit is the slot 0 MSB
  logic             cap;        // this bit is captured
  logic [POS_W-1:0] cpos;       // position of this bit
  logic             chalf;      // half of this bit
  logic [SLOT_W-1:0] cslot;     // slot of this bit
  logic [POS_W-1:0] last;       // last position of a half or frame
  words_t           sh_next;    // shift registers after this bit

  assign is_tdm = (l_r.cfg.fmt == FMT_TDM);
  assign is_i2s = (l_r.cfg.fmt == FMT_I2S);
  // both edges are held so they line up at the same rising edge
  assign smp = (l_r.cfg.pol ^ l_r.cfg.edge_sel) ? neg_r : l_r.pos_d;
  // internal or external frame sync for latching
  assign fs_now = (l_r.cfg.ctrl_mode && l_r.cfg.int_fs) ? l_r.fs_out
                : (l_r.cfg.pol ? neg_r.frame_sync : l_r.pos_d.frame_sync);
  // tdm starts on rise, lj left on rise, i2s left on fall
  assign ev      = is_tdm ? (fs_now && !l_r.fs_prev) : (fs_now != l_r.fs_prev);
  assign ev_half = is_tdm ? 1'b0 : (is_i2s ? fs_now : !fs_now);
  // the offset shifts every slot 0 start, left and right alike
  assign delay = {1'b0, l_r.cfg.offset} + (is_i2s ? I2S_LAG : 6'h00);
  assign start_now = (ev && delay == 6'h00)
                   || (!ev && l_r.armed && l_r.skip == 6'h00);
  assign cap   = start_now || (l_r.state == CAP_RUN);
  assign cpos  = start_now ? '0 : l_r.pos + 10'h001;
  assign chalf = start_now ? (ev ? ev_half : l_r.half_arm) : l_r.half;
  // tdm counts 32 slots, the halves count 16 each
  assign cslot = is_tdm ? cpos[9:5] : {chalf, cpos[8:5]};
  assign last  = is_tdm ? FRAME_LAST : HALF_LAST;

  // per-channel pin choice and slot match
  genvar c;
  generate
    for (c = 0; c < N_CHAN; c++) begin : g_chan
      logic bit_in;  // data bit from the chosen input
      assign bit_in = l_r.cfg.pin_sel[c] ? smp.second_serial_data_input : smp.din1;
      assign sh_next[c] = (cap && cslot == l_r.cfg.slot[c])
                        ? {l_r.sh[c][WORD_BITS-2:0], bit_in}
                        : l_r.sh[c];
    end
  endgenerate

  // capture sequencing, config take-over, internal frame sync
  always_comb begin
    l_nxt = l_r;
    l_nxt.pos_d   = ser_i;
    l_nxt.fs_prev = fs_now;
    // config offer from the system side, two stages
    l_nxt.req_s1 = s_r.req;
    l_nxt.req_s2 = l_r.req_s1;
    if (l_r.req_s2 != l_r.req_seen) begin
      l_nxt.cfg      = s_r.hold;
      l_nxt.req_seen = l_r.req_s2;
    end
    // a frame sync transition arms the offset count
    if (ev) begin
      l_nxt.armed    = (delay != 6'h00);
      l_nxt.skip     = delay - 6'h01;
      l_nxt.half_arm = ev_half;
    end else if (l_r.armed) begin
      if (l_r.skip == 6'h00) begin
        l_nxt.armed = 1'b0;
      end else begin
        l_nxt.skip = l_r.skip - 6'h01;
      end
    end
    // shift the bit, close the half or frame at its last bit
    if (cap) begin
      l_nxt.state = CAP_RUN;
      l_nxt.pos   = cpos;
      l_nxt.half  = chalf;
      l_nxt.sh    = sh_next;
      if (cpos == last) begin
        l_nxt.state = CAP_IDLE;
        if (is_tdm || chalf) begin
          l_nxt.hold = sh_next;
          l_nxt.pub  = ~l_r.pub;
        end
      end
    end
    // internal frame sync, driven only in controller mode
    l_nxt.fs_oe = l_r.cfg.ctrl_mode;
    if (l_r.cfg.ctrl_mode) begin
      l_nxt.gen = l_r.gen + 10'h001;
    end
    if (is_tdm) begin
      l_nxt.fs_out = (l_nxt.gen == '0);
    end else if (is_i2s) begin
      l_nxt.fs_out = l_nxt.gen[POS_W-1];
    end else begin
      l_nxt.fs_out = !l_nxt.gen[POS_W-1];
    end
  end

  // link register
  always_ff @(posedge link_clk_i) begin
    if (lrst_s2) begin
      l_r     <= '0;
      l_r.cfg <= CFG_RST;
    end else begin
      l_r <= l_nxt;
    end
  end

  // outputs straight from flip-flops
  assign wb_o.ack        = s_r.ack;
  assign wb_o.dat        = s_r.rdat;
  assign ser_o.frame_sync     = l_r.fs_out;
  assign ser_o.frame_sync_oe  = l_r.fs_oe;
  assign bclk_int_sel_o  = s_r.bsel;
  assign samples_o       = s_r.samples;
  assign samples_valid_o = s_r.valid;

endmodule : serial_audio_rx_capture_cfg
